/* File: core/cadr_data_regs.sv */
// Counter array data registers: counter bytes, snapshot, six modules.
module cadr_data_regs
	import cadr_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                resetn,
	input  wire cadr_sfr_req_s       sfr_req,
	input  wire cadr_mode_s          mode,
	input  wire logic                count_tick,
	input  wire logic [CADR_NCH-1:0] pwm_enable,
	input  wire logic [CADR_NCH-1:0] pwm16_enable,
	output logic      [7:0]          sfr_rdata,
	output logic      [15:0]         array_counter,
	output logic      [CADR_NCH-1:0] comparator_enable,
	output logic      [CADR_NCH-1:0] compare_match,
	output logic                     module5_mode_lock,
	output logic                     pwm_cycle_wrap
);

	logic [15:0]         counter_r;
	logic [15:0]         counter_nxt;
	logic [7:0]          snap_r;
	logic [7:0]          rdata_r;
	logic [7:0]          rdata_nxt;
	logic                lock_r;
	logic                wrap_r;
	logic                wrap_nxt;
	logic [15:0]         cl_mask;
	logic                wr_cnt_lo;
	logic                wr_cnt_hi;
	logic                rd_cnt_lo;
	logic                rd_cnt_hi;
	logic [CADR_NCH-1:0] wr_lo;
	logic [CADR_NCH-1:0] wr_hi;
	logic [CADR_NCH-1:0] reload_now;
	logic [15:0]         cmp_val [CADR_NCH];
	logic [15:0]         rld_val [CADR_NCH];
	logic [7:0]          ch_rd   [CADR_NCH];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	assign sfr_rdata         = rdata_r;
	assign array_counter     = counter_r;
	assign module5_mode_lock = lock_r;
	assign pwm_cycle_wrap    = wrap_r;

	assign wr_cnt_lo = sfr_req.wr && (sfr_req.addr == CADR_ADDR_CNT_LO);
	assign wr_cnt_hi = sfr_req.wr && (sfr_req.addr == CADR_ADDR_CNT_HI);
	assign rd_cnt_lo = sfr_req.rd && (sfr_req.addr == CADR_ADDR_CNT_LO);
	assign rd_cnt_hi = sfr_req.rd && (sfr_req.addr == CADR_ADDR_CNT_HI);

	always_comb
	begin
		case (mode.cycle_length_select)
			CADR_CL_8:  cl_mask = CADR_MASK_8;
			CADR_CL_9:  cl_mask = CADR_MASK_9;
			CADR_CL_10: cl_mask = CADR_MASK_10;
			CADR_CL_11: cl_mask = CADR_MASK_11;
			default:    cl_mask = CADR_MASK_8;
		endcase
	end

	// A permitted software write replaces the byte and skips that tick;
	// the count lost is one, and software rewrote the counter anyway.
	always_comb
	begin
		counter_nxt = counter_r;
		if (wr_cnt_lo && !mode.watchdog_enable)
			counter_nxt[7:0] = sfr_req.wdata;
		else if (wr_cnt_hi && !mode.watchdog_enable)
			counter_nxt[15:8] = sfr_req.wdata;
		else if (count_tick)
			counter_nxt = counter_r + 16'h0001;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			counter_r <= CADR_RST_WORD;
		else
			counter_r <= counter_nxt;
	end

	// The snapshot keeps a low-then-high read pair coherent even while
	// the counter keeps running between the two reads.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			snap_r <= CADR_RST_BYTE;
		else if (rd_cnt_lo)
			snap_r <= counter_r[15:8];
	end

	assign wrap_nxt = count_tick && ((counter_r & cl_mask) == cl_mask);

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			wrap_r <= 1'b0;
		else
			wrap_r <= wrap_nxt;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			lock_r <= 1'b0;
		else
			lock_r <= mode.watchdog_enable;
	end

	for (genvar i = 0; i < CADR_NCH; i++)
	begin : g_ch
		logic [15:0] mask;
		logic [15:0] sel;

		assign wr_lo[i] = sfr_req.wr && (sfr_req.addr == CADR_ADDR_CPL[i]);
		assign wr_hi[i] = sfr_req.wr && (sfr_req.addr == CADR_ADDR_CPH[i]);
		assign mask = pwm16_enable[i] ? CADR_MASK_16 : cl_mask;
		assign reload_now[i] = wrap_nxt && pwm_enable[i] && !pwm16_enable[i];
		assign sel = mode.auto_reload_select ? rld_val[i] : cmp_val[i];

		always_comb
		begin
			ch_rd[i] = CADR_RD_UNMAPPED;
			if (sfr_req.addr == CADR_ADDR_CPL[i])
				ch_rd[i] = sel[7:0];
			else if (sfr_req.addr == CADR_ADDR_CPH[i])
				ch_rd[i] = sel[15:8];
		end

		cadr_channel u_ch (
			.mclk               (mclk),
			.resetn             (resetn),
			.wr_lo              (wr_lo[i]),
			.wr_hi              (wr_hi[i]),
			.auto_reload_select (mode.auto_reload_select),
			.wdata              (sfr_req.wdata),
			.reload_now         (reload_now[i]),
			.cyc_mask           (mask),
			.count              (counter_r),
			.compare_value      (cmp_val[i]),
			.reload_value       (rld_val[i]),
			.comparator_enable  (comparator_enable[i]),
			.compare_match      (compare_match[i])
		);

		property p_ecom_clr;
			wr_lo[i] |=> !comparator_enable[i];
		endproperty
		a_ecom_clr:
		assert property (p_ecom_clr)
			else $error("compare low write left enable set");

		property p_ecom_set;
			wr_hi[i] && !wr_lo[i] |=> comparator_enable[i];
		endproperty
		a_ecom_set:
		assert property (p_ecom_set)
			else $error("compare high write left enable clear");

		property p_cmp_hi_wr;
			wr_hi[i] && !mode.auto_reload_select
				|=> cmp_val[i][15:8] == $past(sfr_req.wdata);
		endproperty
		a_cmp_hi_wr:
		assert property (p_cmp_hi_wr)
			else $error("compare high byte not written");

		property p_cmp_lo_wr;
			wr_lo[i] && !mode.auto_reload_select
				|=> cmp_val[i][7:0] == $past(sfr_req.wdata);
		endproperty
		a_cmp_lo_wr:
		assert property (p_cmp_lo_wr)
			else $error("compare low byte not written");

		property p_rld_lo_wr;
			wr_lo[i] && mode.auto_reload_select
				|=> rld_val[i][7:0] == $past(sfr_req.wdata)
				&& cmp_val[i] == ($past(reload_now[i])
				? $past(rld_val[i]) : $past(cmp_val[i]));
		endproperty
		a_rld_lo_wr:
		assert property (p_rld_lo_wr)
			else $error("reload low write went astray");

		property p_rld_hi_wr;
			wr_hi[i] && mode.auto_reload_select
				|=> rld_val[i][15:8] == $past(sfr_req.wdata)
				&& cmp_val[i] == ($past(reload_now[i])
				? $past(rld_val[i]) : $past(cmp_val[i]));
		endproperty
		a_rld_hi_wr:
		assert property (p_rld_hi_wr)
			else $error("reload high write went astray");

		property p_sel_read;
			sfr_req.rd && sfr_req.addr == CADR_ADDR_CPL[i]
				|=> sfr_rdata == ($past(mode.auto_reload_select)
				? $past(rld_val[i][7:0]) : $past(cmp_val[i][7:0]));
		endproperty
		a_sel_read:
		assert property (p_sel_read)
			else $error("module low read returned wrong value");

		property p_sel_read_hi;
			sfr_req.rd && sfr_req.addr == CADR_ADDR_CPH[i]
				|=> sfr_rdata == ($past(mode.auto_reload_select)
				? $past(rld_val[i][15:8]) : $past(cmp_val[i][15:8]));
		endproperty
		a_sel_read_hi:
		assert property (p_sel_read_hi)
			else $error("module high read returned wrong value");

		// A compare write in the wrap cycle takes precedence when auto reload select is low, so only clean wraps count.
		property p_reload;
			reload_now[i] && !wr_lo[i] && !wr_hi[i]
				|=> cmp_val[i] == $past(rld_val[i]);
		endproperty
		a_reload:
		assert property (p_reload)
			else $error("module compare not reloaded at cycle wrap");

		property p_no_match_off;
			!comparator_enable[i] |=> !compare_match[i];
		endproperty
		a_no_match_off:
		assert property (p_no_match_off)
			else $error("match while comparator disabled");
	end

	always_comb
	begin
		rdata_nxt = CADR_RD_UNMAPPED;
		if (sfr_req.addr == CADR_ADDR_CNT_LO)
			rdata_nxt = counter_r[7:0];
		else if (sfr_req.addr == CADR_ADDR_CNT_HI)
			rdata_nxt = snap_r;
		for (int k = 0; k < CADR_NCH; k++)
			rdata_nxt = rdata_nxt | ch_rd[k];
	end

	// Read data is registered and holds until the next read strobe.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rdata_r <= CADR_RST_BYTE;
		else if (sfr_req.rd)
			rdata_r <= rdata_nxt;
	end

	sequence s_rd_lo;
		rd_cnt_lo;
	endsequence

	sequence s_rd_hi;
		rd_cnt_hi;
	endsequence

	sequence s_wr_lo;
		wr_cnt_lo;
	endsequence

	sequence s_wr_hi;
		wr_cnt_hi;
	endsequence

	property p_snap_load;
		s_rd_lo |=> snap_r == $past(counter_r[15:8]);
	endproperty
	a_snap_load:
	assert property (p_snap_load)
		else $error("snapshot not loaded on low byte read");

	property p_snap_hold;
		!rd_cnt_lo |=> snap_r == $past(snap_r);
	endproperty
	a_snap_hold:
	assert property (p_snap_hold)
		else $error("snapshot changed without a low read");

	property p_pair;
		s_rd_lo ##1 s_rd_hi |=> sfr_rdata == $past(counter_r[15:8], 2);
	endproperty
	a_pair:
	assert property (p_pair)
		else $error("high read did not return snapshot");

	property p_lo_read;
		s_rd_lo |=> sfr_rdata == $past(counter_r[7:0]);
	endproperty
	a_lo_read:
	assert property (p_lo_read)
		else $error("low read did not return live byte");

	property p_lo_wr;
		s_wr_lo and !mode.watchdog_enable
			|=> array_counter[7:0] == $past(sfr_req.wdata);
	endproperty
	a_lo_wr:
	assert property (p_lo_wr)
		else $error("counter low write lost");

	property p_hi_wr;
		s_wr_hi and !mode.watchdog_enable
			|=> array_counter[15:8] == $past(sfr_req.wdata);
	endproperty
	a_hi_wr:
	assert property (p_hi_wr)
		else $error("counter high write lost");

	property p_lo_prot;
		s_wr_lo and mode.watchdog_enable && !count_tick
			|=> array_counter == $past(array_counter);
	endproperty
	a_lo_prot:
	assert property (p_lo_prot)
		else $error("protected counter low byte changed");

	property p_hi_prot;
		s_wr_hi and mode.watchdog_enable && !count_tick
			|=> array_counter == $past(array_counter);
	endproperty
	a_hi_prot:
	assert property (p_hi_prot)
		else $error("protected counter high byte changed");

	property p_lock;
		mode.watchdog_enable |=> module5_mode_lock;
	endproperty
	a_lock:
	assert property (p_lock)
		else $error("module five mode not locked");

	property p_unlock;
		!mode.watchdog_enable |=> !module5_mode_lock;
	endproperty
	a_unlock:
	assert property (p_unlock)
		else $error("module five mode lock stuck");

	property p_wrap9;
		count_tick && mode.cycle_length_select == CADR_CL_9
			&& counter_r[8:0] == 9'h1ff |=> pwm_cycle_wrap;
	endproperty
	a_wrap9:
	assert property (p_wrap9)
		else $error("nine bit cycle wrap missed");

endmodule // cadr_data_regs

/* File: core/cadr_pkg.sv */
// Constants, types and register map of the counter array data registers.
// Summary of operation
// - Counter low byte readable, writable, resets zero.
// - Counter high byte separate register, resets zero.
// - High byte reads return snapshot latch.
// - Watchdog enabled blocks counter low writes.
// - Watchdog enabled blocks counter high writes.
// - Six module compare low bytes, reset zero.
// - Six module compare high bytes, reset zero.
// - Low address alternatively reaches reload low byte.
// - High address alternatively reaches reload high byte.
// - Auto reload select chooses compare or reload.
// - Compare low write clears comparator enable.
// - Compare high write sets comparator enable.
// - Comparator enable turns on the match comparator.
// - Watchdog enabled locks module five mode register.
// - Cycle length field selects 8-11 bit cycles.
package cadr_pkg;

	localparam int CADR_NCH = 6;

	localparam logic [7:0] CADR_ADDR_CNT_LO = 8'hf9;
	localparam logic [7:0] CADR_ADDR_CNT_HI = 8'hfa;

	// Index i holds module i; module 5 sits in the top slot.
	localparam logic [5:0][7:0] CADR_ADDR_CPL = {
		8'hd2, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb
	};
	localparam logic [5:0][7:0] CADR_ADDR_CPH = {
		8'hd3, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc
	};

	localparam logic [7:0]  CADR_RST_BYTE   = 8'h00;
	localparam logic [15:0] CADR_RST_WORD   = 16'h0000;
	localparam logic        CADR_RST_ENABLE = 1'b0;
	localparam logic [7:0]  CADR_RD_UNMAPPED = 8'h00;

	localparam logic [15:0] CADR_MASK_8  = 16'h00ff;
	localparam logic [15:0] CADR_MASK_9  = 16'h01ff;
	localparam logic [15:0] CADR_MASK_10 = 16'h03ff;
	localparam logic [15:0] CADR_MASK_11 = 16'h07ff;
	localparam logic [15:0] CADR_MASK_16 = 16'hffff;

	typedef enum logic [1:0] {
		CADR_CL_8  = 2'h0,
		CADR_CL_9  = 2'h1,
		CADR_CL_10 = 2'h2,
		CADR_CL_11 = 2'h3
	} cadr_cycle_length_select_e;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} cadr_sfr_req_s;

	typedef struct packed {
		logic        watchdog_enable;
		logic        auto_reload_select;
		cadr_cycle_length_select_e cycle_length_select;
	} cadr_mode_s;

endpackage

/* File: core/cadr_channel.sv */
// One capture/compare module: compare value, reload value, enable, match.
module cadr_channel
	import cadr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic        auto_reload_select,
	input  wire logic [7:0]  wdata,
	input  wire logic        reload_now,
	input  wire logic [15:0] cyc_mask,
	input  wire logic [15:0] count,
	output logic      [15:0] compare_value,
	output logic      [15:0] reload_value,
	output logic             comparator_enable,
	output logic             compare_match
);

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			compare_value <= CADR_RST_WORD;
		else if ((wr_lo || wr_hi) && !auto_reload_select)
		begin
			if (wr_lo)
				compare_value[7:0] <= wdata;
			if (wr_hi)
				compare_value[15:8] <= wdata;
		end
		else if (reload_now)
			compare_value <= reload_value;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			reload_value <= CADR_RST_WORD;
		else if (auto_reload_select)
		begin
			if (wr_lo)
				reload_value[7:0] <= wdata;
			if (wr_hi)
				reload_value[15:8] <= wdata;
		end
	end

	// The enable follows the address, whichever value the write reached.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			comparator_enable <= CADR_RST_ENABLE;
		else if (wr_lo)
			comparator_enable <= 1'b0;
		else if (wr_hi)
			comparator_enable <= 1'b1;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			compare_match <= 1'b0;
		else
			compare_match <= comparator_enable &&
				((count & cyc_mask) == (compare_value & cyc_mask));
	end

endmodule // cadr_channel

/* File: testbench/cadr_data_regs_tb_top.sv */
// Self-checking bench for the counter array data registers.
module cadr_data_regs_tb_top
	import cadr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                mclk;
	logic                resetn;
	cadr_sfr_req_s       sfr_req;
	cadr_mode_s          mode;
	logic                count_tick;
	logic [CADR_NCH-1:0] pwm_enable;
	logic [CADR_NCH-1:0] pwm16_enable;
	logic [7:0]          sfr_rdata;
	logic [15:0]         array_counter;
	logic [CADR_NCH-1:0] comparator_enable;
	logic [CADR_NCH-1:0] compare_match;
	logic                module5_mode_lock;
	logic                pwm_cycle_wrap;
	logic [15:0]         mask;
	int                  miscompares;
	int                  tests_run;

	cadr_data_regs uut (
		.mclk              (mclk),
		.resetn            (resetn),
		.sfr_req           (sfr_req),
		.mode              (mode),
		.count_tick        (count_tick),
		.pwm_enable        (pwm_enable),
		.pwm16_enable      (pwm16_enable),
		.sfr_rdata         (sfr_rdata),
		.array_counter     (array_counter),
		.comparator_enable (comparator_enable),
		.compare_match     (compare_match),
		.module5_mode_lock (module5_mode_lock),
		.pwm_cycle_wrap    (pwm_cycle_wrap)
	);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_req.addr  <= a;
		sfr_req.wdata <= d;
		sfr_req.wr    <= 1'b1;
		@(posedge mclk);
		sfr_req.wr <= 1'b0;
		#1;
	endtask

	// Read data holds until the next read, so sampling a cycle late is safe.
	task automatic read_check(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		sfr_req.addr <= a;
		sfr_req.rd   <= 1'b1;
		@(posedge mclk);
		sfr_req.rd <= 1'b0;
		@(posedge mclk);
		#1;
		check({8'h00, sfr_rdata}, {8'h00, e});
	endtask

	// The counter runs through both reads; the high byte must still match.
	task automatic read_pair(input logic [15:0] v);
		@(posedge mclk);
		sfr_req.addr <= CADR_ADDR_CNT_LO;
		sfr_req.rd   <= 1'b1;
		count_tick   <= 1'b1;
		@(posedge mclk);
		sfr_req.addr <= CADR_ADDR_CNT_HI;
		#1;
		check({8'h00, sfr_rdata}, {8'h00, v[7:0]});
		@(posedge mclk);
		sfr_req.rd <= 1'b0;
		count_tick <= 1'b0;
		#1;
		check({8'h00, sfr_rdata}, {8'h00, v[15:8]});
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			count_tick <= 1'b1;
		end
		@(posedge mclk);
		count_tick <= 1'b0;
		#1;
	endtask

	task automatic set_counter(input logic [15:0] v);
		reg_write(CADR_ADDR_CNT_HI, v[15:8]);
		reg_write(CADR_ADDR_CNT_LO, v[7:0]);
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		miscompares++;
		summarize();
	end

	initial
	begin
		miscompares  = 0;
		tests_run    = 0;
		resetn       = 1'b0;
		sfr_req      = '0;
		mode         = '0;
		count_tick   = 1'b0;
		pwm_enable   = '0;
		pwm16_enable = '0;
		mask         = 16'h0000;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		check({10'h000, comparator_enable}, 16'h0000);
		for (int i = 0; i < CADR_NCH; i++)
		begin
			read_check(CADR_ADDR_CPL[i], 8'h00);
			read_check(CADR_ADDR_CPH[i], 8'h00);
		end
		read_check(CADR_ADDR_CNT_LO, 8'h00);
		read_check(CADR_ADDR_CNT_HI, 8'h00);
		reg_write(8'h01, 8'h5a);
		read_check(8'h01, CADR_RD_UNMAPPED);

		// The high byte must come from the snapshot, not the live counter.
		set_counter(16'h12ff);
		check(array_counter, 16'h12ff);
		read_check(CADR_ADDR_CNT_LO, 8'hff);
		ticks(1);
		check({15'h0000, pwm_cycle_wrap}, 16'h0001);
		check(array_counter, 16'h1300);
		read_check(CADR_ADDR_CNT_HI, 8'h12);
		read_check(CADR_ADDR_CNT_LO, 8'h00);
		read_check(CADR_ADDR_CNT_HI, 8'h13);

		@(posedge mclk);
		mode.watchdog_enable <= 1'b1;
		set_counter(16'h4321);
		check({8'h00, array_counter[7:0]}, 16'h0000);
		check({8'h00, array_counter[15:8]}, 16'h0013);
		check({15'h0000, module5_mode_lock}, 16'h0001);
		@(posedge mclk);
		mode.watchdog_enable <= 1'b0;
		set_counter(16'h4321);
		check(array_counter, 16'h4321);
		check({15'h0000, module5_mode_lock}, 16'h0000);
		set_counter(16'h12ff);
		read_pair(16'h12ff);
		check(array_counter, 16'h1301);

		for (int i = 0; i < CADR_NCH; i++)
		begin
			reg_write(CADR_ADDR_CPH[i], 8'h50 + 8'(i));
			check({15'h0000, comparator_enable[i]}, 16'h0001);
			reg_write(CADR_ADDR_CPL[i], 8'ha0 + 8'(i));
			check({15'h0000, comparator_enable[i]}, 16'h0000);
		end
		@(posedge mclk);
		mode.auto_reload_select <= 1'b1;
		for (int i = 0; i < CADR_NCH; i++)
		begin
			reg_write(CADR_ADDR_CPL[i], 8'h30 + 8'(i));
			reg_write(CADR_ADDR_CPH[i], 8'h0c + 8'(i));
			check({15'h0000, comparator_enable[i]}, 16'h0001);
			read_check(CADR_ADDR_CPL[i], 8'h30 + 8'(i));
			read_check(CADR_ADDR_CPH[i], 8'h0c + 8'(i));
		end
		@(posedge mclk);
		mode.auto_reload_select <= 1'b0;
		pwm_enable              <= 6'h03;
		pwm16_enable            <= 6'h02;
		for (int i = 0; i < CADR_NCH; i++)
		begin
			read_check(CADR_ADDR_CPL[i], 8'ha0 + 8'(i));
			read_check(CADR_ADDR_CPH[i], 8'h50 + 8'(i));
		end

		// Each length must reload only at its own all-ones count.
		for (int k = 0; k < 4; k++)
		begin
			mask = (16'h0100 << k) - 16'h0001;
			@(posedge mclk);
			mode.cycle_length_select <= cadr_cycle_length_select_e'(k);
			reg_write(CADR_ADDR_CPL[0], 8'h00);
			reg_write(CADR_ADDR_CPH[0], 8'h00);
			set_counter((mask >> 1) - 16'h0001);
			ticks(2);
			check({15'h0000, pwm_cycle_wrap}, 16'h0000);
			read_check(CADR_ADDR_CPL[0], 8'h00);
			set_counter(mask - 16'h0001);
			ticks(2);
			check({15'h0000, pwm_cycle_wrap}, 16'h0001);
			read_check(CADR_ADDR_CPL[0], 8'h30);
			read_check(CADR_ADDR_CPH[0], 8'h0c);
			read_check(CADR_ADDR_CPL[1], 8'ha1);
		end

		@(posedge mclk);
		mode.cycle_length_select <= CADR_CL_8;
		pwm_enable               <= 6'h00;
		set_counter(16'h0020);
		reg_write(CADR_ADDR_CPL[2], 8'h20);
		reg_write(CADR_ADDR_CPH[2], 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		check({15'h0000, compare_match[2]}, 16'h0001);
		reg_write(CADR_ADDR_CPL[2], 8'h20);
		repeat (2) @(posedge mclk);
		#1;
		check({15'h0000, compare_match[2]}, 16'h0000);

		// A reset in mid-run must clear values written since the first one.
		@(posedge mclk);
		resetn <= 1'b0;
		@(posedge mclk);
		resetn <= 1'b1;
		#1;
		check(array_counter, 16'h0000);
		check({10'h000, comparator_enable}, 16'h0000);
		read_check(CADR_ADDR_CPL[2], 8'h00);
		read_check(CADR_ADDR_CPH[0], 8'h00);
		read_check(CADR_ADDR_CNT_HI, 8'h00);
		summarize();
	end

endmodule // cadr_data_regs_tb_top
